// ===== tc8_timer.sv
/*
 * 8-bit timer/counter with one output compare channel: counter unit,
 * mode sequencing, comparator, double-buffered compare value, flags,
 * forced compare, match blocking after counter writes and compare output.
 * Assumes the processor side drives one-cycle write strobes on clock and
 * that the oscillator pin is asynchronous to clock.
 */
// Notes on behaviour
// - each timer tick clears, increments or decrements the counter per mode
// - clock select zero stops the counter completely
// - processor may read and write the counter at any time
// - a counter write beats any clear or count in the same cycle
// - tick from io clock by default, from oscillator pin when async select set
// - the two-bit waveform mode field sets the counting sequence
// - overflow flag set where the mode says; it can request an interrupt
// - counter equal to compare value sets compare flag on the next tick
// - enabled compare flag requests interrupt; cleared by ack or writing one
// - each request is visible as a flag and masked individually
// - compare value buffered in pwm modes, updated only at top (max)
// - buffered: writes reach the buffer; otherwise the active compare value
// - waveform uses match, mode, action, plus force and bottom events and count direction
// - force strobe in non-pwm modes acts on output only, no flag, no clear
// - any counter write blocks compare flag and output matches in the next timer tick; clear-on-match mode still clears the counter
// - compare output keeps its value across mode changes
// - output action changes take effect at once, no buffering
// - bottom is 0x00, max is 0xFF, top is max or compare value
// - normal mode counts up, wraps max to zero, overflow as it becomes zero
// - clear-on-match mode clears the counter on a match; compare value is top
// - fast pwm counts bottom to max; clear on match, set at bottom or reverse
// - action zero leaves the output alone on a match in every mode
`timescale 1ns/1ps

module tc8_timer
    import tc8_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       clock_enable,
    // control fields
    input  wire logic [1:0] waveform_mode_select,
    input  wire logic [1:0] compare_output_action,
    input  wire logic [2:0] clock_select,
    input  wire logic       async_clock_select,
    input  wire logic       force_compare_strobe,
    // counter access
    input  wire logic       counter_write,
    input  wire logic [7:0] counter_wdata,
    output logic      [7:0] counter_value,
    // compare value access
    input  wire logic       compare_write,
    input  wire logic [7:0] compare_wdata,
    output logic      [7:0] compare_value,
    output logic      [7:0] compare_active,
    // flags, masks and requests
    input  wire logic       compare_irq_enable,
    input  wire logic       overflow_irq_enable,
    input  wire logic       compare_flag_write_one,
    input  wire logic       overflow_flag_write_one,
    input  wire logic       compare_irq_ack,
    input  wire logic       overflow_irq_ack,
    output logic            compare_flag,
    output logic            overflow_flag,
    output logic            compare_irq,
    output logic            overflow_irq,
    // pins
    input  wire logic       osc_pin_in,
    output logic            osc_pin_out,
    output logic            compare_output
);

    tc8_mode_t  mode;
    logic       timer_tick;
    logic       counting_down;
    logic       match_block;
    logic [7:0] compare_buffer;
    logic [7:0] next_counter;
    logic       next_down;
    logic       is_pwm;
    logic       at_bottom;
    logic       at_max;
    logic       at_top;
    logic       match;
    logic       match_event;
    logic       force_event;
    logic       bottom_event;
    logic       overflow_event;
    logic       buffer_load;
    logic       compare_clear;
    logic       overflow_clear;

    ////////////////////////////////////////////////////////////////////////
    // tick generation
    tc8_prescale u_prescale
    (
        .clock              (clock),
        .nrst               (nrst),
        .clock_enable       (clock_enable),
        .clock_select       (clock_select),
        .async_clock_select (async_clock_select),
        .osc_pin_in         (osc_pin_in),
        .osc_pin_out        (osc_pin_out),
        .timer_tick         (timer_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // mode and extreme-value decoding
    assign mode      = tc8_mode_t'(waveform_mode_select);
    assign is_pwm    = tc8_is_pwm(mode);
    assign at_bottom = (counter_value == `TC8_BOTTOM);
    assign at_max    = (counter_value == `TC8_MAX);
    // top is the compare value in clear-on-match mode, max elsewhere
    assign at_top    = (mode == tc8_clear_on_match_mode) ? (counter_value == compare_active) : at_max;

    // comparator runs continuously against the active value
    assign match = (counter_value == compare_active);

    // a match acts on the tick, unless a counter write blocked it
    assign match_event = timer_tick && match && !match_block && !counter_write;

    // forced match only exists outside the pwm modes
    assign force_event = force_compare_strobe && !is_pwm;

    // bottom of the fast pwm ramp: the tick that wraps max to zero
    assign bottom_event = timer_tick && !counter_write && (mode == tc8_fast_pwm) && at_max;

    ////////////////////////////////////////////////////////////////////////
    // overflow point per mode
    always_comb
    begin
        case (mode)
            tc8_phase_pwm:
                overflow_event = timer_tick && !counter_write && counting_down
                                 && (counter_value == `TC8_ONE);
            default:
                // counter goes max to zero on this tick
                overflow_event = timer_tick && !counter_write && at_max;
        endcase
    end

    // buffered value moves across at top of the count only
    assign buffer_load = timer_tick && is_pwm && at_max;

    ////////////////////////////////////////////////////////////////////////
    // counter next value and direction per mode
    always_comb
    begin
        next_counter = counter_value;
        next_down    = counting_down;
        case (mode)
            tc8_normal:
                next_counter = counter_value + `TC8_ONE;
            tc8_clear_on_match_mode:
                // clear on match, else keep counting up
                next_counter = match ? `TC8_BOTTOM : counter_value + `TC8_ONE;
            tc8_fast_pwm:
                next_counter = at_max ? `TC8_BOTTOM : counter_value + `TC8_ONE;
            tc8_phase_pwm:
            begin
                // dual slope: turn round at max and at bottom
                if (at_max)
                    next_down = 1'b1;
                else if (at_bottom)
                    next_down = 1'b0;
                if (at_max || (counting_down && !at_bottom))
                    next_counter = counter_value - `TC8_ONE;
                else
                    next_counter = counter_value + `TC8_ONE;
            end
            default:
                next_counter = counter_value;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // counter register: processor write first, then the tick
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            counter_value <= `TC8_BOTTOM;
            counting_down <= 1'b0;
        end
        else if (clock_enable)
        begin
            if (counter_write)
                counter_value <= counter_wdata;
            else if (timer_tick)
            begin
                counter_value <= next_counter;
                counting_down <= next_down;
            end
            if (mode != tc8_phase_pwm)
                counting_down <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // match blocking: armed by a counter write, spent by the next tick
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            match_block <= 1'b0;
        else if (clock_enable)
        begin
            if (counter_write)
                match_block <= 1'b1;
            else if (timer_tick)
                match_block <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare value: buffer and active register
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            compare_buffer <= `TC8_BOTTOM;
            compare_active <= `TC8_BOTTOM;
        end
        else if (clock_enable)
        begin
            if (compare_write)
                compare_buffer <= compare_wdata;
            if (compare_write && !is_pwm)
                compare_active <= compare_wdata;
            else if (buffer_load)
                compare_active <= compare_buffer;
        end
    end

    // processor view: the buffer, which tracks active when unbuffered
    assign compare_value = compare_buffer;

    ////////////////////////////////////////////////////////////////////////
    // flags: hardware set wins over ack or write-one clear
    assign compare_clear  = compare_flag_write_one || compare_irq_ack;
    assign overflow_clear = overflow_flag_write_one || overflow_irq_ack;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            compare_flag  <= 1'b0;
            overflow_flag <= 1'b0;
        end
        else if (clock_enable)
        begin
            if (match_event)
                compare_flag <= 1'b1;
            else if (compare_clear)
                compare_flag <= 1'b0;
            if (overflow_event)
                overflow_flag <= 1'b1;
            else if (overflow_clear)
                overflow_flag <= 1'b0;
        end
    end

    // per-source masking of requests
    assign compare_irq  = compare_flag && compare_irq_enable;
    assign overflow_irq = overflow_flag && overflow_irq_enable;

    ////////////////////////////////////////////////////////////////////////
    // waveform generator
    tc8_wavegen u_wavegen
    (
        .clock                 (clock),
        .nrst                  (nrst),
        .clock_enable          (clock_enable),
        .mode                  (mode),
        .compare_output_action (compare_output_action),
        .match_event           (match_event),
        .force_event           (force_event),
        .bottom_event          (bottom_event),
        .counting_down         (counting_down),
        .compare_output        (compare_output)
    );

endmodule : tc8_timer

// ===== tc8_regs.svh
/*
 * Named constants for the 8-bit timer/counter with one compare channel:
 * count limits, compare output action codes, clock select codes and prescaler taps.
 * Assumes it is included by bare name from the package only, ahead of the design modules.
 */
`ifndef TC8_REGS_SVH
`define TC8_REGS_SVH

// count limits
`define TC8_BOTTOM        8'h00
`define TC8_MAX           8'hFF
`define TC8_ONE           8'h01

// compare output action codes
`define TC8_ACT_NONE      2'h0
`define TC8_ACT_TOGGLE    2'h1
`define TC8_ACT_CLEAR     2'h2
`define TC8_ACT_SET       2'h3

// clock select codes
`define TC8_CS_STOP       3'h0
`define TC8_CS_DIV1       3'h1
`define TC8_CS_DIV8       3'h2
`define TC8_CS_DIV32      3'h3
`define TC8_CS_DIV64      3'h4
`define TC8_CS_DIV128     3'h5
`define TC8_CS_DIV256     3'h6
`define TC8_CS_DIV1024    3'h7

// prescaler terminal counts (divisor minus one)
`define TC8_PRE_WIDTH     10
`define TC8_PRE_DIV8      10'h007
`define TC8_PRE_DIV32     10'h01F
`define TC8_PRE_DIV64     10'h03F
`define TC8_PRE_DIV128    10'h07F
`define TC8_PRE_DIV256    10'h0FF
`define TC8_PRE_DIV1024   10'h3FF
`define TC8_PRE_ZERO      10'h000
`define TC8_PRE_ONE       10'h001

`endif

// ===== tc8_pkg.sv
/*
 * Types shared by the timer/counter modules.
 * Assumes tc8_regs.svh sits in the same folder.
 */
`include "tc8_regs.svh"

package tc8_pkg;

    typedef logic [7:0] tc8_byte_t;

    // enum order gives the two-bit mode field encoding
    typedef enum logic [1:0]
    {
        tc8_normal,
        tc8_phase_pwm,
        tc8_clear_on_match_mode,
        tc8_fast_pwm
    } tc8_mode_t;

    // pwm modes use the buffered compare value
    function automatic logic tc8_is_pwm(input tc8_mode_t mode);
        return (mode == tc8_phase_pwm) || (mode == tc8_fast_pwm);
    endfunction : tc8_is_pwm

endpackage : tc8_pkg

// ===== tc8_prescale.sv
/*
 * Tick source: picks the io clock or the synchronised oscillator pin,
 * divides it by the selected factor and gives a one-cycle timer tick.
 * Assumes osc_pin_in is asynchronous to clock and much slower than it.
 */
`timescale 1ns/1ps

module tc8_prescale
    import tc8_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       clock_enable,
    input  wire logic [2:0] clock_select,
    input  wire logic       async_clock_select,
    input  wire logic       osc_pin_in,
    output logic            osc_pin_out,
    output logic            timer_tick
);

    logic                       osc_meta;
    logic                       osc_sync;
    logic                       osc_prev;
    logic [`TC8_PRE_WIDTH-1:0]  prescale;
    logic [`TC8_PRE_WIDTH-1:0]  terminal;
    logic                       source_edge;
    logic                       at_terminal;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser, then edge memory on the clean copy
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else if (clock_enable)
        begin
            osc_meta <= osc_pin_in;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // source pulse: every io cycle, or each rising oscillator edge
    assign source_edge = async_clock_select ? (osc_sync & ~osc_prev) : 1'b1;
    assign osc_pin_out = ~osc_prev;  // inverted feedback for the crystal

    // terminal count per clock select
    always_comb
    begin
        case (clock_select)
            `TC8_CS_DIV8:    terminal = `TC8_PRE_DIV8;
            `TC8_CS_DIV32:   terminal = `TC8_PRE_DIV32;
            `TC8_CS_DIV64:   terminal = `TC8_PRE_DIV64;
            `TC8_CS_DIV128:  terminal = `TC8_PRE_DIV128;
            `TC8_CS_DIV256:  terminal = `TC8_PRE_DIV256;
            `TC8_CS_DIV1024: terminal = `TC8_PRE_DIV1024;
            default:         terminal = `TC8_PRE_ZERO;
        endcase
    end

    assign at_terminal = (prescale >= terminal);

    ////////////////////////////////////////////////////////////////////////
    // prescaler counter; stopped select holds it cleared
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            prescale <= `TC8_PRE_ZERO;
        else if (clock_enable)
        begin
            if (clock_select == `TC8_CS_STOP)
                prescale <= `TC8_PRE_ZERO;
            else if (source_edge)
                prescale <= at_terminal ? `TC8_PRE_ZERO : prescale + `TC8_PRE_ONE;
        end
    end

    // no tick at all while stopped
    assign timer_tick = clock_enable && (clock_select != `TC8_CS_STOP)
                        && source_edge && at_terminal;

endmodule : tc8_prescale

// ===== tc8_wavegen.sv
/*
 * Waveform generator: holds the compare output register and updates it
 * on matches, forced matches and the bottom of the count.
 * Assumes match and bottom events are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps

module tc8_wavegen
    import tc8_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       clock_enable,
    input  tc8_mode_t       mode,
    input  wire logic [1:0] compare_output_action,
    input  wire logic       match_event,
    input  wire logic       force_event,
    input  wire logic       bottom_event,
    input  wire logic       counting_down,
    output logic            compare_output
);

    logic next_compare_output;

    ////////////////////////////////////////////////////////////////////////
    // output decision per mode and action
    always_comb
    begin
        next_compare_output = compare_output;
        case (mode)
            tc8_fast_pwm:
            begin
                // match first, bottom last so bottom wins on a shared tick
                if (match_event && compare_output_action == `TC8_ACT_CLEAR)
                    next_compare_output = 1'b0;
                if (match_event && compare_output_action == `TC8_ACT_SET)
                    next_compare_output = 1'b1;
                if (bottom_event && compare_output_action == `TC8_ACT_CLEAR)
                    next_compare_output = 1'b1;
                if (bottom_event && compare_output_action == `TC8_ACT_SET)
                    next_compare_output = 1'b0;
            end
            tc8_phase_pwm:
            begin
                // clear on up-count match, set on down-count match (non-inverting)
                if (match_event && compare_output_action == `TC8_ACT_CLEAR)
                    next_compare_output = counting_down;
                if (match_event && compare_output_action == `TC8_ACT_SET)
                    next_compare_output = ~counting_down;
            end
            default:
            begin
                // non-pwm: real or forced match set, clear or toggle
                if (match_event || force_event)
                begin
                    case (compare_output_action)
                        `TC8_ACT_TOGGLE: next_compare_output = ~compare_output;
                        `TC8_ACT_CLEAR:  next_compare_output = 1'b0;
                        `TC8_ACT_SET:    next_compare_output = 1'b1;
                        default:         next_compare_output = compare_output;
                    endcase
                end
            end
        endcase
    end

    // action field is read live, never buffered
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            compare_output <= 1'b0;
        else if (clock_enable)
            compare_output <= next_compare_output;
    end

endmodule : tc8_wavegen

// ===== tc8_timer_chk.sv
/*
 * Port-level checker for the 8-bit timer/counter.
 * Assumes one clock domain and a bind from tb_top.
 */
`timescale 1ns/1ps

module tc8_chk
    import tc8_pkg::*;
(
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       clock_enable,
    input wire logic [1:0] waveform_mode_select,
    input wire logic [1:0] compare_output_action,
    input wire logic [2:0] clock_select,
    input wire logic       async_clock_select,
    input wire logic       force_compare_strobe,
    input wire logic       counter_write,
    input wire logic [7:0] counter_wdata,
    input wire logic [7:0] counter_value,
    input wire logic       compare_write,
    input wire logic [7:0] compare_wdata,
    input wire logic [7:0] compare_value,
    input wire logic [7:0] compare_active,
    input wire logic       compare_irq_enable,
    input wire logic       compare_flag_write_one,
    input wire logic       compare_irq_ack,
    input wire logic       compare_flag,
    input wire logic       overflow_flag,
    input wire logic       compare_irq,
    input wire logic       compare_output
);
////////////////////////////////////////////////////////////////////////////////
// full-rate ticking from the io clock
wire       run = clock_enable && clock_select == 3'h1 && !async_clock_select;
wire [1:0] md  = waveform_mode_select;

default clocking cb @(posedge clock); endclocking
default disable iff (!nrst);

// ticking for two cycles with no counter write in either
sequence s_live;
    run && $past(run) && !counter_write && !$past(counter_write);
endsequence
sequence s_wrap;
    counter_value == 8'h00 && overflow_flag;
endsequence

////////////////////////////////////////////////////////////////////////////////
a_stop_holds: assert property (clock_enable && clock_select == 3'h0 && !counter_write
    |=> $stable(counter_value)) else $error("counter moved while stopped");
a_write_wins: assert property (clock_enable && counter_write
    |=> counter_value == $past(counter_wdata)) else $error("counter write lost");
a_count_up: assert property (s_live ##0 md == 2'h0
    |=> counter_value == $past(counter_value) + 8'h01) else $error("no increment");
a_ovf_wrap: assert property (s_live ##0 md == 2'h0 && counter_value == 8'hFF
    |=> s_wrap) else $error("no overflow at wrap");
a_cmp_flag: assert property (s_live ##0 md == 2'h0 && counter_value == compare_active
    |=> compare_flag) else $error("match without flag");
a_wr_blocks: assert property (run && $past(run) && $past(counter_write) && !counter_write
    && counter_value == compare_active && !compare_flag |=> !compare_flag) else $error("match not blocked");
a_ctc_clear: assert property (s_live ##0 md == 2'h2 && counter_value == compare_active
    |=> counter_value == 8'h00) else $error("no clear on match");
a_force_out: assert property (clock_enable && force_compare_strobe && !md[0]
    && compare_output_action == 2'h3 |=> compare_output) else $error("force did not set");
a_force_noflag: assert property (clock_enable && force_compare_strobe && clock_select == 3'h0
    && !compare_flag |=> !compare_flag) else $error("force set flag");
a_pwm_buffer: assert property (clock_enable && compare_write && md == 2'h3 && clock_select == 3'h0
    |=> compare_value == $past(compare_wdata) && $stable(compare_active)) else $error("buffer bypassed");
a_fast_pwm: assert property (s_live ##0 md == 2'h3 && counter_value == 8'hFF && compare_output_action == 2'h2
    |=> compare_output && counter_value == 8'h00 && compare_active == $past(compare_value)) else $error("bad bottom");
a_irq_mask: assert property (compare_irq == (compare_flag && compare_irq_enable))
    else $error("irq mask wrong");
a_flag_clear: assert property (clock_enable && counter_value != compare_active
    && (compare_flag_write_one || compare_irq_ack) |=> !compare_flag) else $error("flag not cleared");

endmodule : tc8_chk

// ===== tb_top.sv
/*
 * Self-checking bench for the 8-bit timer/counter.
 * Assumes tc8_pkg, the design files and tc8_timer_chk.sv are compiled first.
 */
`timescale 1ns/1ps

module tb_top;
logic       clock = 1'h0, nrst = 1'h0, clock_enable = 1'h1, async_clock_select = 1'h0, osc_pin_in = 1'h0;
logic [1:0] waveform_mode_select = 2'h0, compare_output_action = 2'h0;
logic [2:0] clock_select = 3'h0;
logic       force_compare_strobe = 1'h0, counter_write = 1'h0, compare_write = 1'h0;
logic       compare_irq_enable = 1'h1, overflow_irq_enable = 1'h1, compare_irq_ack = 1'h0;
logic       compare_flag_write_one = 1'h0, overflow_flag_write_one = 1'h0, overflow_irq_ack = 1'h0;
logic [7:0] counter_wdata = 8'h00, compare_wdata = 8'h00, counter_value, compare_value, compare_active;
logic       compare_flag, overflow_flag, compare_irq, overflow_irq, osc_pin_out, compare_output;
int         err_total = 0, check_count = 0, i;
logic [1:0] act_tab [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1};
logic       out_tab [6] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1};

////////////////////////////////////////////////////////////////////////////////
// clock at 125 MHz
always #4 clock = ~clock;

tc8_timer dut (.clock, .nrst, .clock_enable, .waveform_mode_select, .compare_output_action,
    .clock_select, .async_clock_select, .force_compare_strobe, .counter_write, .counter_wdata,
    .counter_value, .compare_write, .compare_wdata, .compare_value, .compare_active,
    .compare_irq_enable, .overflow_irq_enable, .compare_flag_write_one, .overflow_flag_write_one,
    .compare_irq_ack, .overflow_irq_ack, .compare_flag, .overflow_flag, .compare_irq,
    .overflow_irq, .osc_pin_in, .osc_pin_out, .compare_output);

////////////////////////////////////////////////////////////////////////////////
// compare, verdict and access tasks
task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
        err_total++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : chk

task give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
endtask : give_verdict

task step(input int n);
    repeat (n) @(posedge clock);
endtask : step

// one-cycle strobe: 0 counter, 1 compare, 2 force, 3/4 compare flag clear, 5 overflow clear
task put(input int k, input logic [7:0] d);
    @(posedge clock);
    case (k)
        0: counter_write <= 1'h1;
        1: compare_write <= 1'h1;
        2: force_compare_strobe <= 1'h1;
        3: compare_flag_write_one <= 1'h1;
        4: compare_irq_ack <= 1'h1;
        default: overflow_flag_write_one <= 1'h1;
    endcase
    counter_wdata <= d;
    compare_wdata <= d;
    @(posedge clock);
    {counter_write, compare_write, force_compare_strobe} <= 3'h0;
    {compare_flag_write_one, compare_irq_ack, overflow_flag_write_one} <= 3'h0;
    @(negedge clock);
endtask : put

task cfg(input logic [1:0] m, input logic [1:0] a, input logic [2:0] c);
    @(posedge clock);
    waveform_mode_select <= m;
    compare_output_action <= a;
    clock_select <= c;
    @(negedge clock);
endtask : cfg

task wait_cnt(input logic [7:0] v);
    int n;
    n = 0;
    while (counter_value !== v && n < 600)
    begin
        @(negedge clock);
        n++;
    end
    if (n == 600)
    begin
        chk(counter_value, v);
        give_verdict();
    end
endtask : wait_cnt

////////////////////////////////////////////////////////////////////////////////
// main sequence
initial
begin
    step(12);
    nrst <= 1'h1;
    step(5);
    @(negedge clock);
    chk(counter_value, 8'h00);
    chk({compare_flag, overflow_flag, compare_output, osc_pin_out}, 8'h01);
    $display("test reset done");
    put(0, 8'hFD);
    cfg(2'h0, 2'h0, 3'h1);
    wait_cnt(8'h00);
    chk({overflow_flag, overflow_irq}, 8'h03);
    put(3, 8'h00);
    put(5, 8'h00);
    chk({overflow_flag, compare_flag}, 8'h00);
    put(1, 8'h20);
    chk(compare_active, 8'h20);
    wait_cnt(8'h21);
    chk({compare_flag, compare_irq}, 8'h03);
    @(posedge clock) compare_irq_enable <= 1'h0;
    @(negedge clock);
    chk(compare_irq, 1'h0);
    put(4, 8'h00);
    chk(compare_flag, 1'h0);
    $display("test normal done");
    put(1, 8'h40);
    put(0, 8'h40);
    chk(counter_value, 8'h40);
    step(3);
    chk(compare_flag, 1'h0);
    cfg(2'h0, 2'h0, 3'h0);
    put(0, 8'h40);
    step(4);
    cfg(2'h0, 2'h0, 3'h1);
    step(3);
    chk(compare_flag, 1'h0);
    $display("test blocking done");
    cfg(2'h0, 2'h0, 3'h0);
    for (i = 0; i < 6; i++)
    begin
        cfg(2'h0, act_tab[i], 3'h0);
        put(2, 8'h00);
        chk(compare_output, out_tab[i]);
    end
    chk(compare_flag, 1'h0);
    cfg(2'h3, 2'h0, 3'h0);
    chk(compare_output, 1'h1);
    $display("test force done");
    cfg(2'h2, 2'h0, 3'h0);
    put(0, 8'h00);
    put(1, 8'h05);
    cfg(2'h2, 2'h0, 3'h1);
    step(30);
    @(negedge clock);
    chk(counter_value <= 8'h05, 1'h1);
    chk({compare_flag, compare_output}, 8'h03);
    $display("test top done");
    cfg(2'h2, 2'h2, 3'h0);
    put(2, 8'h00);
    cfg(2'h3, 2'h2, 3'h0);
    put(1, 8'h80);
    chk({compare_value, compare_active}, 16'h8005);
    put(0, 8'hF0);
    cfg(2'h3, 2'h2, 3'h1);
    wait_cnt(8'h00);
    chk({compare_active, 7'h00, compare_output}, 16'h8001);
    wait_cnt(8'h81);
    chk(compare_output, 1'h0);
    $display("test fast pwm done");
    cfg(2'h0, 2'h0, 3'h0);
    @(posedge clock) async_clock_select <= 1'h1;
    put(0, 8'h00);
    cfg(2'h0, 2'h0, 3'h1);
    step(10);
    @(negedge clock);
    chk(counter_value, 8'h00);
    for (i = 0; i < 4; i++)
    begin
        @(posedge clock) osc_pin_in <= 1'h1;
        step(6);
        osc_pin_in <= 1'h0;
        step(6);
    end
    @(negedge clock);
    chk(counter_value, 8'h04);
    $display("test async done");
    give_verdict();
end

endmodule : tb_top

bind tc8_timer tc8_chk u_chk (.clock, .nrst, .clock_enable, .waveform_mode_select,
    .compare_output_action, .clock_select, .async_clock_select, .force_compare_strobe,
    .counter_write, .counter_wdata, .counter_value, .compare_write, .compare_wdata,
    .compare_value, .compare_active, .compare_irq_enable, .compare_flag_write_one,
    .compare_irq_ack, .compare_flag, .overflow_flag, .compare_irq, .compare_output);
